// file: src/lnkrc_pkg.sv
// shared constants, types and register map of the link reset/clock/strap block
package lnkrc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_MHZ          = 100;
  localparam int LINK_FAST_MHZ    = 50;
  localparam int LINK_SLOW_MHZ    = 5;
  localparam int FILTER_NS        = 200;
  localparam int HOLD_US          = 500;
  // half periods of the driven link clock, in pclk cycles
  localparam int HALF_FAST_CYC    = CLK_MHZ / (2 * LINK_FAST_MHZ);
  localparam int HALF_SLOW_CYC    = CLK_MHZ / (2 * LINK_SLOW_MHZ);
  // least times round up
  localparam int FILTER_CYC       = (FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC         = HOLD_US * CLK_MHZ;
  localparam int HALF_W           = 5;
  localparam int WIDTH_W          = 17;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam int          CTRL_RST_BIT  = 15;
  localparam int          CTRL_LP_BIT   = 1;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam int          ST_CODE_LSB   = 0;
  localparam int          ST_RSVD_BIT   = 4;
  localparam int          ST_SLOW_BIT   = 5;
  localparam int          ST_HOLD_BIT   = 6;
  localparam int          ST_SYNC_LSB   = 8;
  localparam int          SYNC_CNT_W    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // strap codes, order {test enable, bit2, bit1, bit0}
  localparam logic [3:0] STRAP_MODE0    = 4'h0;
  localparam logic [3:0] STRAP_MODE1    = 4'h3;
  localparam logic [3:0] STRAP_ISOLATE  = 4'h7;
  localparam logic [3:0] STRAP_XOR      = 4'h8;
  localparam logic [3:0] STRAP_MODE2    = 4'h9;
  localparam logic [3:0] STRAP_TESTING  = 4'ha;
  localparam logic [3:0] STRAP_MODE3    = 4'hb;
  localparam logic [3:0] STRAP_MODE4    = 4'hc;
  localparam logic [3:0] STRAP_PWRDN    = 4'hf;

  typedef enum logic [1:0] {
    LED_CFG_A,
    LED_CFG_B,
    LED_CFG_C
  } lnkrc_led_cfg_t;

  typedef struct packed {
    logic           pin_is_advertise_ten_only;
    logic           pin_is_off;
    logic           isolate;
    logic           xor_tree;
    logic           test_mode;
    logic           enhanced_tx;
    logic           reserved;
    lnkrc_led_cfg_t led_cfg;
  } lnkrc_mode_t;

  typedef struct packed {
    logic activity;
    logic link_up;
    logic speed_100;
  } lnkrc_led_in_t;

endpackage : lnkrc_pkg

// file: src/lnkrc_clk_div.sv
// glitch-free two-rate divider that drives the link clock
`timescale 1ns/10ps
module lnkrc_clk_div
  import lnkrc_pkg::*;
#(
  parameter logic [HALF_W-1:0] HALF_FAST = HALF_W'(HALF_FAST_CYC),
  parameter logic [HALF_W-1:0] HALF_SLOW = HALF_W'(HALF_SLOW_CYC)
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // rate select
  input  wire logic slow,
  // link clock
  output logic      clk_out,
  output logic      rise
);

  logic [HALF_W-1:0] cnt_q;
  logic [HALF_W-1:0] half_q;
  logic              clk_q;
  logic              last_w;
  logic [HALF_W-1:0] half_d;

  assign last_w = (cnt_q == half_q - HALF_W'(1));
  assign half_d = slow ? HALF_SLOW : HALF_FAST;

  // rate is switched only at a toggle so no runt edge and no stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      half_q <= HALF_FAST;
      clk_q  <= 1'b0;
    end else if (last_w) begin
      cnt_q  <= '0;
      half_q <= half_d;
      clk_q  <= ~clk_q;
    end else begin
      cnt_q  <= cnt_q + HALF_W'(1);
    end
  end

  assign clk_out = clk_q;
  assign rise    = last_w & ~clk_q;

endmodule : lnkrc_clk_div

// file: src/lnkrc_top.sv
// reset/sync decode, link clock generation and strap decode with an apb slave
`timescale 1ns/10ps

module lnkrc_top
  import lnkrc_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // host link
  input  wire logic          host_reset_sync_in,
  output logic               host_link_clock_out,
  output logic               host_word_sync,
  // line state from the phy core, same clock
  input  wire logic          line_speed_100,
  input  wire logic          low_power,
  input  wire lnkrc_led_in_t led_in,
  // strap and shared pins
  input  wire logic          strap_bit3_test_enable,
  input  wire logic          strap_bit2,
  input  wire logic          strap_bit1,
  input  wire logic          strap_bit0,
  input  wire logic          single_pin_off_n,
  // decoded state
  output logic               device_reset_n,
  output lnkrc_mode_t        mode,
  output logic               advertise_ten_only,
  output logic               outputs_tristate,
  output logic               power_down,
  // leds
  output logic               activity_led_n,
  output logic               speed_led_n,
  output logic               link_led_n
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] rs_sync_q;
  logic [3:0] strap_s1_q;
  logic [3:0] strap_s2_q;
  logic       off_s1_q;
  logic       off_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_sync_q  <= 2'b00;
      off_s1_q   <= 1'b1;
      off_s2_q   <= 1'b1;
    end else begin
      rs_sync_q  <= {rs_sync_q[0], host_reset_sync_in};
      off_s1_q   <= single_pin_off_n;
      off_s2_q   <= off_s1_q;
    end
  end

  // no reset: the straps must already be through when presetn releases the latch
  always_ff @(posedge pclk) begin
    strap_s1_q <= {strap_bit3_test_enable, strap_bit2, strap_bit1, strap_bit0};
    strap_s2_q <= strap_s1_q;
  end

  wire rs_level_w = rs_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // link clock
  logic ctrl_lp_q;
  logic link_slow_w;

  // reduced power or 10 Mb/s both run slow
  assign link_slow_w = ~line_speed_100 | low_power | ctrl_lp_q;

  // divider only sees presetn: an internal reset must not stop the clock
  lnkrc_clk_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .slow    (link_slow_w),
    .clk_out (host_link_clock_out),
    .rise    ()
  );

  wire [WIDTH_W-1:0] period_cyc_w = link_slow_w ? WIDTH_W'(2 * HALF_SLOW_CYC)
                                                : WIDTH_W'(2 * HALF_FAST_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // reset/sync pulse width decode
  logic [WIDTH_W-1:0]    width_q;
  logic                  rs_prev_q;
  logic                  hold_rst_q;
  logic                  sync_q;
  logic [SYNC_CNT_W-1:0] sync_cnt_q;
  logic                  soft_rst_q;
  logic                  int_rst_q;

  wire               fall_w     = rs_prev_q & ~rs_level_w;
  wire               is_sync_w  = fall_w && (width_q <= period_cyc_w);
  wire [WIDTH_W-1:0] hold_lim_w = WIDTH_W'(HOLD_CYCLES);
  wire               hold_hit_w = rs_level_w && (width_q >= hold_lim_w - WIDTH_W'(1));

  // counter saturates so a hold of any length keeps the reset applied
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_q    <= '0;
      rs_prev_q  <= 1'b0;
      hold_rst_q <= 1'b0;
      sync_q     <= 1'b0;
    end else begin
      rs_prev_q  <= rs_level_w;
      sync_q     <= is_sync_w;
      hold_rst_q <= hold_hit_w;
      if (!rs_level_w) begin
        width_q <= '0;
      end else if (width_q != hold_lim_w) begin
        width_q <= width_q + WIDTH_W'(1);
      end
    end
  end

  // wider than one period but short of the hold: no sync, no reset
  assign host_word_sync = sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cnt_q <= '0;
    end else if (int_rst_q) begin
      sync_cnt_q <= '0;
    end else if (sync_q) begin
      sync_cnt_q <= sync_cnt_q + SYNC_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal reset: pin, long hold or soft bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_rst_q <= 1'b1;
    end else begin
      int_rst_q <= hold_rst_q | soft_rst_q;
    end
  end

  assign device_reset_n = ~int_rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // strap latch, refreshed while the internal reset is active
  logic [3:0] strap_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q <= 4'h0;
    end else if (int_rst_q) begin
      strap_q <= strap_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap decode
  lnkrc_mode_t mode_w;

  always_comb begin
    mode_w         = '0;
    mode_w.led_cfg = LED_CFG_A;
    case (strap_q)
      STRAP_MODE0: begin
        mode_w.pin_is_advertise_ten_only = 1'b1;
      end
      STRAP_MODE1: begin
        mode_w.led_cfg    = LED_CFG_B;
        mode_w.pin_is_off = 1'b1;
      end
      STRAP_ISOLATE: begin
        mode_w.isolate = 1'b1;
      end
      STRAP_XOR: begin
        mode_w.xor_tree = 1'b1;
      end
      STRAP_TESTING: begin
        mode_w.test_mode = 1'b1;
      end
      STRAP_MODE2: begin
        mode_w.led_cfg    = LED_CFG_C;
        mode_w.pin_is_off = 1'b1;
      end
      STRAP_MODE3: begin
        mode_w.led_cfg     = LED_CFG_B;
        mode_w.pin_is_off  = 1'b1;
        mode_w.enhanced_tx = 1'b1;
      end
      STRAP_MODE4: begin
        mode_w.led_cfg     = LED_CFG_C;
        mode_w.pin_is_off  = 1'b1;
        mode_w.enhanced_tx = 1'b1;
      end
      STRAP_PWRDN: begin
        mode_w.isolate = 1'b1;
      end
      default: begin
        // reserved codes fall back to isolate as the safe choice
        mode_w.isolate  = 1'b1;
        mode_w.reserved = 1'b1;
      end
    endcase
  end

  assign mode = mode_w;

  wire pin_off_w = mode_w.pin_is_off & ~off_s2_q;

  assign advertise_ten_only = mode_w.pin_is_advertise_ten_only & off_s2_q;
  assign outputs_tristate   = mode_w.isolate | mode_w.xor_tree | pin_off_w;
  assign power_down         = mode_w.isolate | pin_off_w;

  ////////////////////////////////////////////////////////////////////////////
  // leds, active low and registered
  logic act_led_q;
  logic spd_led_q;
  logic lnk_led_q;
  logic spd_on_w;
  logic lnk_on_w;

  assign spd_on_w = (mode_w.led_cfg == LED_CFG_A) ? led_in.speed_100
                  : (led_in.link_up & led_in.speed_100);
  assign lnk_on_w = (mode_w.led_cfg == LED_CFG_C) ? (led_in.link_up & ~led_in.speed_100)
                  : led_in.link_up;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_led_q <= 1'b1;
      spd_led_q <= 1'b1;
      lnk_led_q <= 1'b1;
    end else begin
      act_led_q <= ~led_in.activity;
      spd_led_q <= ~spd_on_w;
      lnk_led_q <= ~lnk_on_w;
    end
  end

  assign activity_led_n = act_led_q;
  assign speed_led_n    = spd_led_q;
  assign link_led_n     = lnk_led_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, read data registered in the setup cycle
  logic [31:0] prdata_q;

  wire sel_ctrl_w   = (paddr == CTRL_OFS);
  wire sel_status_w = (paddr == STATUS_OFS);
  wire mapped_w     = sel_ctrl_w | sel_status_w;
  wire setup_w      = psel & ~penable;
  wire wr_ctrl_w    = psel & penable & pwrite & sel_ctrl_w;

  wire [31:0] ctrl_rd_w = {30'h0000_0000, ctrl_lp_q, 1'b0};
  wire [31:0] status_rd_w = {16'h0000, sync_cnt_q, 1'b0, hold_rst_q, link_slow_w,
                             mode_w.reserved, strap_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q   <= 32'h0000_0000;
      ctrl_lp_q  <= CTRL_RESET[CTRL_LP_BIT];
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_ctrl_w & pwdata[CTRL_RST_BIT];
      if (int_rst_q) begin
        ctrl_lp_q <= CTRL_RESET[CTRL_LP_BIT];
      end else if (wr_ctrl_w) begin
        ctrl_lp_q <= pwdata[CTRL_LP_BIT];
      end
      if (setup_w) begin
        prdata_q <= sel_ctrl_w ? ctrl_rd_w : (sel_status_w ? status_rd_w : 32'h0000_0000);
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped_w;

endmodule : lnkrc_top

// file: verification/lnkrc_props.sv
// port-level assertions for the link reset/clock/strap block
`timescale 1ns/10ps
module lnkrc_props
  import lnkrc_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  // clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // host link and line state
  input wire logic          host_reset_sync_in,
  input wire logic          host_link_clock_out,
  input wire logic          host_word_sync,
  input wire logic          line_speed_100,
  input wire logic          low_power,
  input wire lnkrc_led_in_t led_in,
  input wire logic          single_pin_off_n,
  // decoded state and leds
  input wire logic          device_reset_n,
  input wire lnkrc_mode_t   mode,
  input wire logic          advertise_ten_only,
  input wire logic          outputs_tristate,
  input wire logic          power_down,
  input wire logic          activity_led_n,
  input wire logic          speed_led_n,
  input wire logic          link_led_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] w_q;
  logic        slow;
  logic        want_spd;
  logic        want_lnk;
  assign slow     = !line_speed_100 || low_power;
  assign want_spd = led_in.speed_100 && (mode.led_cfg == LED_CFG_A || led_in.link_up);
  assign want_lnk = led_in.link_up && !(mode.led_cfg == LED_CFG_C && led_in.speed_100);
  // width of the last raw pulse; the design sees it two cycles later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_q <= '0;
    end else if ($rose(host_reset_sync_in)) begin
      w_q <= 16'h0001;
    end else if (host_reset_sync_in && w_q != 16'hffff) begin
      w_q <= w_q + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_strap_hold: assert property (
    device_reset_n && $past(device_reset_n) |-> $stable(mode)) else $error("mode moved");
  a_clock_alive: assert property (
    1'b1 |-> ##[1:10] $changed(host_link_clock_out)) else $error("link clock stopped");
  a_fast_rate: assert property (
    (!slow)[*8] ##1 (!slow)[*8] |-> $changed(host_link_clock_out)) else $error("not 50 MHz");
  a_slow_rate: assert property (
    slow[*6] ##0 $changed(host_link_clock_out) |=> $stable(host_link_clock_out)[*8])
    else $error("not 5 MHz");
  a_sync_short: assert property (
    $fell(host_reset_sync_in) && w_q <= 2 |-> ##[1:8] host_word_sync) else $error("no sync");
  a_wide_ignored: assert property (
    $fell(host_reset_sync_in) && w_q > 20 && w_q < HOLD_CYCLES |-> ##1 !host_word_sync[*8])
    else $error("wide pulse gave sync");
  a_hold_reset: assert property (
    host_reset_sync_in && w_q == HOLD_CYCLES |-> ##[1:10] !device_reset_n)
    else $error("long hold gave no reset");
  a_pin_off: assert property (
    (mode.pin_is_off && $stable(single_pin_off_n))[*4] |->
      power_down == !single_pin_off_n && outputs_tristate == !single_pin_off_n)
    else $error("pin off wrong");
  a_adv_ten: assert property (
    (mode.pin_is_advertise_ten_only && $stable(single_pin_off_n))[*4] |->
      advertise_ten_only == single_pin_off_n) else $error("advertise wrong");
  a_tri_modes: assert property (
    mode.isolate || mode.xor_tree |-> outputs_tristate) else $error("not tri-stated");
  a_led_speed: assert property (
    device_reset_n ##1 device_reset_n |-> speed_led_n == !$past(want_spd))
    else $error("speed led wrong");
  a_led_link: assert property (
    device_reset_n ##1 device_reset_n |-> link_led_n == !$past(want_lnk))
    else $error("link led wrong");
  a_led_activity: assert property (
    device_reset_n ##1 device_reset_n |-> activity_led_n == !$past(led_in.activity))
    else $error("activity led wrong");
endmodule : lnkrc_props

bind lnkrc_top lnkrc_props #(.HOLD_CYCLES(HOLD_CYCLES)) props_u (
  .pclk, .presetn, .host_reset_sync_in, .host_link_clock_out, .host_word_sync,
  .line_speed_100, .low_power, .led_in, .single_pin_off_n, .device_reset_n, .mode,
  .advertise_ten_only, .outputs_tristate, .power_down, .activity_led_n, .speed_led_n,
  .link_led_n
);

// file: verification/lnkrc_ctrl_model.sv
// host-side controller model that drives the reset/sync line
`timescale 1ns/10ps
module lnkrc_ctrl_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link clock from the device, pulse request
  input  wire logic        link_clk,
  input  wire logic        go,
  input  wire logic [15:0] len,
  // reset/sync line
  output logic             host_reset_sync_in,
  output logic             busy
);
  logic        arm_q;
  logic        lk_q;
  logic [15:0] cnt_q;
  logic        start;
  // start on a link clock rise so a one-period pulse is word aligned
  assign start = arm_q && link_clk && !lk_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= 1'b0;
      lk_q  <= 1'b0;
      cnt_q <= '0;
    end else begin
      lk_q  <= link_clk;
      arm_q <= go || (arm_q && !start);
      cnt_q <= start ? len : cnt_q - 16'(cnt_q != '0);
    end
  end
  // driven low between pulses, never left floating
  assign host_reset_sync_in = cnt_q != '0;
  assign busy               = arm_q || host_reset_sync_in;
endmodule : lnkrc_ctrl_model

// file: verification/lnkrc_top_tb_top.sv
// self-checking bench for the link reset/clock/strap block
`timescale 1ns/10ps
module lnkrc_top_tb_top
  import lnkrc_pkg::*;
;
  localparam int HC = 64;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic host_reset_sync_in, host_link_clock_out, host_word_sync, line_speed_100, low_power;
  logic strap_bit3_test_enable, strap_bit2, strap_bit1, strap_bit0, single_pin_off_n;
  logic device_reset_n, advertise_ten_only, outputs_tristate, power_down;
  logic activity_led_n, speed_led_n, link_led_n;
  lnkrc_led_in_t led_in;
  lnkrc_mode_t mode, em, mk;
  logic [15:0] len;
  logic [7:0] scnt;
  int miscompares, comparisons, cyc, rcnt, r0, h;
  logic [15:0] pl[5] = '{16'h0002, 16'h0003, 16'h0014, 16'h0015, 16'h000a};

  lnkrc_top #(.HOLD_CYCLES(HC)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .host_reset_sync_in, .host_link_clock_out, .host_word_sync, .line_speed_100, .low_power,
    .led_in, .strap_bit3_test_enable, .strap_bit2, .strap_bit1, .strap_bit0,
    .single_pin_off_n, .device_reset_n, .mode, .advertise_ten_only, .outputs_tristate,
    .power_down, .activity_led_n, .speed_led_n, .link_led_n
  );
  lnkrc_ctrl_model ctl_u (.pclk, .presetn, .link_clk(host_link_clock_out), .go, .len,
                          .host_reset_sync_in, .busy);

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (presetn && !device_reset_n) rcnt++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic latch(input logic [3:0] c);
    @(posedge pclk);
    {strap_bit3_test_enable, strap_bit2, strap_bit1, strap_bit0} <= c;
    repeat (4) @(posedge pclk);
    apb(1'b1, CTRL_OFS, 32'h0000_8000);
    repeat (8) @(posedge pclk);
  endtask : latch
  task automatic pulse(input logic [15:0] l);
    @(posedge pclk);
    {go, len} <= {1'b1, l};
    @(posedge pclk);
    go <= 1'b0;
    do @(posedge pclk); while (busy !== 1'b0);
    repeat (10) @(posedge pclk);
  endtask : pulse
  task automatic half_per(output int hp);
    logic v;
    v = host_link_clock_out;
    while (host_link_clock_out === v) @(posedge pclk);
    v = host_link_clock_out;
    hp = 0;
    while (host_link_clock_out === v) begin @(posedge pclk); hp++; end
  endtask : half_per
  function automatic lnkrc_mode_t exp_mode(input logic [3:0] c);
    lnkrc_mode_t m;
    m = '0;
    m.pin_is_advertise_ten_only = c == STRAP_MODE0;
    m.pin_is_off = c inside {STRAP_MODE1, STRAP_MODE2, STRAP_MODE3, STRAP_MODE4};
    m.xor_tree = c == STRAP_XOR;
    m.test_mode = c == STRAP_TESTING;
    m.enhanced_tx = c inside {STRAP_MODE3, STRAP_MODE4};
    m.reserved = !(c inside {STRAP_MODE0, STRAP_MODE1, STRAP_ISOLATE, STRAP_XOR, STRAP_MODE2,
                             STRAP_TESTING, STRAP_MODE3, STRAP_MODE4, STRAP_PWRDN});
    m.isolate = c == STRAP_ISOLATE || m.reserved;
    m.led_cfg = c inside {STRAP_MODE2, STRAP_MODE4} ? LED_CFG_C :
                c inside {STRAP_MODE1, STRAP_MODE3} ? LED_CFG_B : LED_CFG_A;
    return m;
  endfunction : exp_mode
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, go, len} = '0;
    {line_speed_100, low_power, led_in, single_pin_off_n} = {1'b1, 1'b0, 3'h0, 1'b1};
    {strap_bit3_test_enable, strap_bit2, strap_bit1, strap_bit0} = STRAP_MODE2;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, '0);
    chk("ctrl", rd, CTRL_RESET);
    apb(1'b0, STATUS_OFS, '0);
    chk("boot", rd[3:0], STRAP_MODE2);
    apb(1'b1, 12'h008, 32'hffff_ffff);
    chk("err", err, 32'h0000_0001);
    for (int c = 0; c < 16; c++) begin
      led_in <= 3'(c);
      latch(4'(c));
      {strap_bit3_test_enable, strap_bit2, strap_bit1, strap_bit0} <= ~4'(c);
      repeat (4) @(posedge pclk);
      apb(1'b0, STATUS_OFS, '0);
      em = exp_mode(4'(c));
      mk = '1;
      mk.isolate = c != 15;
      if (!(em.pin_is_off || em.pin_is_advertise_ten_only)) mk.led_cfg = LED_CFG_A;
      chk("code", rd[4:0], {em.reserved, 4'(c)});
      chk("mode", 32'(mode & mk), 32'(em & mk));
      chk("tri", outputs_tristate, em.isolate | em.xor_tree | (c == 15));
      chk("pd", power_down, em.isolate | (c == 15));
      chk("adv", advertise_ten_only, em.pin_is_advertise_ten_only);
    end
    latch(STRAP_MODE1);
    single_pin_off_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("off", {outputs_tristate, power_down}, 2'b11);
    single_pin_off_n <= 1'b1;
    $display("test straps done");
    for (int i = 0; i < 3; i++) begin
      line_speed_100 <= i != 1;
      low_power <= i == 2;
      repeat (30) @(posedge pclk);
      half_per(h);
      chk("half", h, (i == 0) ? 1 : 10);
      apb(1'b0, STATUS_OFS, '0);
      chk("slow", rd[ST_SLOW_BIT], i != 0);
    end
    {line_speed_100, low_power} <= 2'b00;
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    apb(1'b0, CTRL_OFS, '0);
    chk("ctrl", rd, 32'h0000_0002);
    latch(STRAP_MODE1);
    apb(1'b0, CTRL_OFS, '0);
    chk("ctrl", rd, CTRL_RESET);
    $display("test clock done");
    scnt = '0;
    foreach (pl[i]) begin
      line_speed_100 <= i < 2;
      repeat (30) @(posedge pclk);
      pulse(pl[i]);
      scnt += 8'(i % 2 == 0);
      apb(1'b0, STATUS_OFS, '0);
      chk("sync", rd[15:8], scnt);
    end
    r0 = rcnt;
    pulse(16'(HC + 30));
    chk("hold", rcnt - r0 > 20, 32'h0000_0001);
    apb(1'b0, STATUS_OFS, '0);
    chk("clr", rd[15:8], 32'h0000_0000);
    $display("test reset sync done");
    report_and_stop();
  end
endmodule : lnkrc_top_tb_top
